// ===== ccomb_defs.vh
`ifndef CCOMB_DEFS_VH
`define CCOMB_DEFS_VH

// function vector geometry
`define CCOMB_NFN          45
`define CCOMB_FNW          6
`define CCOMB_NTERM        6
`define CCOMB_NAW          16

// per-function combination tables, bit n is function n
`define CCOMB_AND_MASK     45'h18F0_0000_0BDC
`define CCOMB_LOWACT_MASK  45'h0000_0000_001C
`define CCOMB_NONE_MASK    45'h0000_0000_0003

// fixed control word bit positions
`define CCOMB_FW_ON        4'h0
`define CCOMB_FW_VDISC     4'h1
`define CCOMB_FW_FSTOP     4'h2
`define CCOMB_FW_OPEN      4'h3
`define CCOMB_FW_RFG_EN    4'h4
`define CCOMB_FW_RFG_STOP  4'h5
`define CCOMB_FW_SP_EN     4'h6
`define CCOMB_FW_FACK      4'h7
`define CCOMB_FW_VALID     4'hA

// function numbers driven by fixed control word bits
`define CCOMB_FN_VDISC     6'h03
`define CCOMB_FN_FSTOP     6'h04
`define CCOMB_FN_FACK      6'h05
`define CCOMB_FN_RFG_EN    6'h09
`define CCOMB_FN_RFG_STOP  6'h0A
`define CCOMB_FN_SP_EN     6'h0B

// register byte offsets
`define CCOMB_OFS_FIXED    8'h00
`define CCOMB_OFS_ASGW     8'h04
`define CCOMB_OFS_STATUS   8'h08
`define CCOMB_OFS_FUNC_LO  8'h0C
`define CCOMB_OFS_FUNC_HI  8'h10
`define CCOMB_OFS_TSEL     8'h20
`define CCOMB_OFS_ATAB     8'h40

// reset values
`define CCOMB_RST_FIXED    16'h0000
`define CCOMB_RST_ASGW     16'h0000
`define CCOMB_RST_SEL      6'h00

// axi responses
`define CCOMB_RESP_OKAY    2'h0
`define CCOMB_RESP_SLVERR  2'h2

`endif

// ===== ccomb_regfile.v
`timescale 1ns/1ps
`include "ccomb_defs.vh"

// assignment table: one function number per assignable control word bit
module ccomb_regfile (
  input  wire                                   aclk,
  input  wire                                   aresetn,
  input  wire                                   wr_en,
  input  wire [3:0]                             wr_addr,
  input  wire [`CCOMB_FNW-1:0]                  wr_data,
  input  wire [3:0]                             rd_addr,
  output reg  [`CCOMB_FNW-1:0]                  rd_data,
  output wire [`CCOMB_NAW*`CCOMB_FNW-1:0]       all_q
);

  reg [`CCOMB_FNW-1:0] mem_q [0:`CCOMB_NAW-1];

  genvar g;
  generate
    for (g = 0; g < `CCOMB_NAW; g = g + 1) begin : g_ent
      always @(posedge aclk) begin
        if (!aresetn) begin
          mem_q[g] <= `CCOMB_RST_SEL;
        end else if (wr_en && wr_addr == g) begin
          mem_q[g] <= wr_data;
        end
      end
      assign all_q[g*`CCOMB_FNW +: `CCOMB_FNW] = mem_q[g];
    end
  endgenerate

  always @(posedge aclk) begin
    if (!aresetn) begin
      rd_data <= `CCOMB_RST_SEL;
    end else begin
      rd_data <= mem_q[rd_addr];
    end
  end

endmodule // ccomb_regfile

// ===== ccomb_combiner.v
// Overview of operation
// R1 - merge terminal, fixed and assignable word per function
// R2 - function 2 low active, sources ANDed
// R3 - function 3 low active, fixed bit 1, ANDed
// R4 - function 4 low active, fixed bit 2, ANDed
// R5 - function 6 ANDed across sources
// R6 - function 12 ORed across sources
// R7 - functions 13 to 18 ORed
// R8 - functions 19 to 23 ORed
// R9 - function 24 ORed
// R10 - functions 25 to 28 ORed
// R11 - functions 31 and 32 ORed
// R12 - functions 33, 34 and set 4 ORed
// R13 - functions 36 and 37 ANDed
// R14 - function 38 ANDed
// R15 - function 39 ANDed
// R16 - function 40 ORed
// R17 - functions 43 and 44 ANDed
// R18 - host maps assignable bit n to function
// R19 - fixed bit 10 qualifies interface control words
// R20 - low-active inverted; result registered on clock
// R21 - unlisted or unassigned sources contribute neutral value
`timescale 1ns/1ps
`include "ccomb_defs.vh"

module ccomb_combiner (
  input  wire                    aclk,
  input  wire                    aresetn,
  input  wire [`CCOMB_NTERM-1:0] term_in,
  input  wire                    term_switch_on,
  input  wire                    term_op_enable,
  output reg  [`CCOMB_NFN-1:0]   func_out,
  output reg                     switch_on,
  output reg                     op_enable,
  input  wire [31:0]             s_axi_awaddr,
  input  wire [2:0]              s_axi_awprot,
  input  wire                    s_axi_awvalid,
  output wire                    s_axi_awready,
  input  wire [31:0]             s_axi_wdata,
  input  wire [3:0]              s_axi_wstrb,
  input  wire                    s_axi_wvalid,
  output wire                    s_axi_wready,
  output reg  [1:0]              s_axi_bresp,
  output reg                     s_axi_bvalid,
  input  wire                    s_axi_bready,
  input  wire [31:0]             s_axi_araddr,
  input  wire [2:0]              s_axi_arprot,
  input  wire                    s_axi_arvalid,
  output wire                    s_axi_arready,
  output reg  [31:0]             s_axi_rdata,
  output reg  [1:0]              s_axi_rresp,
  output reg                     s_axi_rvalid,
  input  wire                    s_axi_rready
);

  localparam NFN = `CCOMB_NFN;
  localparam FNW = `CCOMB_FNW;

  // software-visible state
  reg  [15:0]              fixed_control_word_q;
  reg  [15:0]              assignable_control_word_q;
  reg  [FNW-1:0]           term_sel_q [0:`CCOMB_NTERM-1];
  wire [`CCOMB_NAW*FNW-1:0] atab_all;
  wire [FNW-1:0]           atab_rd;

  // bus handshake state
  reg         aw_got_q;
  reg         w_got_q;
  reg  [7:0]  awaddr_q;
  reg  [31:0] wdata_q;
  reg  [3:0]  wstrb_q;
  reg         rd_pend_q;
  reg  [7:0]  araddr_q;

  function [NFN-1:0] fn_onehot;
    input [FNW-1:0] num;
    begin
      if (num < NFN) begin
        fn_onehot = {{(NFN-1){1'b0}}, 1'b1} << num;
      end else begin
        fn_onehot = {NFN{1'b0}};
      end
    end
  endfunction

  function [FNW-1:0] fixed_fn;
    input [2:0] k;
    begin
      case (k)
        3'h0:    fixed_fn = `CCOMB_FN_VDISC;
        3'h1:    fixed_fn = `CCOMB_FN_FSTOP;
        3'h2:    fixed_fn = `CCOMB_FN_FACK;
        3'h3:    fixed_fn = `CCOMB_FN_RFG_EN;
        3'h4:    fixed_fn = `CCOMB_FN_RFG_STOP;
        default: fixed_fn = `CCOMB_FN_SP_EN;
      endcase
    end
  endfunction

  function [3:0] fixed_bit;
    input [2:0] k;
    begin
      case (k)
        3'h0:    fixed_bit = `CCOMB_FW_VDISC;
        3'h1:    fixed_bit = `CCOMB_FW_FSTOP;
        3'h2:    fixed_bit = `CCOMB_FW_FACK;
        3'h3:    fixed_bit = `CCOMB_FW_RFG_EN;
        3'h4:    fixed_bit = `CCOMB_FW_RFG_STOP;
        default: fixed_bit = `CCOMB_FW_SP_EN;
      endcase
    end
  endfunction

  // combination network
  wire iface_valid = fixed_control_word_q[`CCOMB_FW_VALID]; // [R19]

  reg [NFN-1:0] and_ok;
  reg [NFN-1:0] or_hit;
  reg [NFN-1:0] oh;
  reg [NFN-1:0] func_d;
  reg           lvl;
  integer       i;

  always @* begin
    and_ok = {NFN{1'b1}}; // [R21]
    or_hit = {NFN{1'b0}}; // [R21]
    oh     = {NFN{1'b0}};
    lvl    = 1'b0;
    for (i = 0; i < `CCOMB_NTERM; i = i + 1) begin
      oh     = fn_onehot(term_sel_q[i]); // [R1]
      lvl    = term_in[i];
      and_ok = and_ok & ~(oh & {NFN{~lvl}});
      or_hit = or_hit | (oh & {NFN{lvl}});
    end
    for (i = 0; i < `CCOMB_NAW; i = i + 1) begin
      oh     = fn_onehot(atab_all[i*FNW +: FNW]) & {NFN{iface_valid}}; // [R18] [R19]
      lvl    = assignable_control_word_q[i];
      and_ok = and_ok & ~(oh & {NFN{~lvl}});
      or_hit = or_hit | (oh & {NFN{lvl}});
    end
    for (i = 0; i < 6; i = i + 1) begin
      oh     = fn_onehot(fixed_fn(i[2:0])) & {NFN{iface_valid}}; // [R3] [R4] [R19]
      lvl    = fixed_control_word_q[fixed_bit(i[2:0])];
      and_ok = and_ok & ~(oh & {NFN{~lvl}});
      or_hit = or_hit | (oh & {NFN{lvl}});
    end
    // [R5] [R6] [R7] [R8] [R9] [R10] [R11] [R12] [R13] [R14] [R15] [R16] [R17]
    func_d = (`CCOMB_AND_MASK & and_ok) | (~`CCOMB_AND_MASK & or_hit);
    // low-active: raw levels ANDed, then turned into an active-high stop request
    func_d = (func_d & ~`CCOMB_LOWACT_MASK) | (~and_ok & `CCOMB_LOWACT_MASK); // [R2] [R20]
    func_d = func_d & ~`CCOMB_NONE_MASK;
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      func_out  <= {NFN{1'b0}};
      switch_on <= 1'b0;
      op_enable <= 1'b0;
    end else begin
      func_out  <= func_d; // [R20]
      switch_on <= term_switch_on &
                   (fixed_control_word_q[`CCOMB_FW_ON] | ~iface_valid);
      op_enable <= term_op_enable &
                   (fixed_control_word_q[`CCOMB_FW_OPEN] | ~iface_valid);
    end
  end

  // axi4-lite write path
  assign s_axi_awready = ~aw_got_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_got_q & ~s_axi_bvalid;

  wire       aw_hs   = s_axi_awvalid & s_axi_awready;
  wire       w_hs    = s_axi_wvalid & s_axi_wready;
  wire       have_aw = aw_got_q | aw_hs;
  wire       have_w  = w_got_q | w_hs;
  wire       do_wr   = have_aw & have_w;
  wire [7:0] wa      = aw_hs ? s_axi_awaddr[7:0] : awaddr_q;
  wire [31:0] wd     = w_hs ? s_axi_wdata : wdata_q;
  wire [3:0] ws      = w_hs ? s_axi_wstrb : wstrb_q;
  wire       hi32    = |(aw_hs ? s_axi_awaddr[31:8] : 24'h000000);
  reg        hi32_q;

  wire wr_fixed = (wa == `CCOMB_OFS_FIXED);
  wire wr_asgw  = (wa == `CCOMB_OFS_ASGW);
  wire wr_tsel  = (wa[7:5] == 3'h1) && (wa[4:2] < 3'h6) && (wa[1:0] == 2'h0);
  wire wr_atab  = (wa[7:6] == 2'h1) && (wa[1:0] == 2'h0);
  wire wr_ok    = ~(aw_hs ? hi32 : hi32_q) & (wr_fixed | wr_asgw | wr_tsel | wr_atab);

  ccomb_regfile ccomb_regfile_inst (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr_en   (do_wr & wr_ok & wr_atab & ws[0]),
    .wr_addr (wa[5:2]),
    .wr_data (wd[FNW-1:0]),
    .rd_addr (s_axi_araddr[5:2]),
    .rd_data (atab_rd),
    .all_q   (atab_all)
  );

  genvar g;
  generate
    for (g = 0; g < `CCOMB_NTERM; g = g + 1) begin : g_tsel
      always @(posedge aclk) begin
        if (!aresetn) begin
          term_sel_q[g] <= `CCOMB_RST_SEL;
        end else if (do_wr && wr_ok && wr_tsel && wa[4:2] == g && ws[0]) begin
          term_sel_q[g] <= wd[FNW-1:0];
        end
      end
    end
  endgenerate

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q                  <= 1'b0;
      w_got_q                   <= 1'b0;
      awaddr_q                  <= 8'h00;
      hi32_q                    <= 1'b0;
      wdata_q                   <= 32'h0000_0000;
      wstrb_q                   <= 4'h0;
      s_axi_bvalid              <= 1'b0;
      s_axi_bresp               <= `CCOMB_RESP_OKAY;
      fixed_control_word_q      <= `CCOMB_RST_FIXED;
      assignable_control_word_q <= `CCOMB_RST_ASGW;
    end else begin
      if (aw_hs) begin
        awaddr_q <= s_axi_awaddr[7:0];
        hi32_q   <= hi32;
      end
      if (w_hs) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_got_q     <= 1'b0;
        w_got_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `CCOMB_RESP_OKAY : `CCOMB_RESP_SLVERR;
        if (wr_ok && wr_fixed) begin
          if (ws[0]) fixed_control_word_q[7:0]  <= wd[7:0];
          if (ws[1]) fixed_control_word_q[15:8] <= wd[15:8];
        end
        if (wr_ok && wr_asgw) begin
          if (ws[0]) assignable_control_word_q[7:0]  <= wd[7:0];
          if (ws[1]) assignable_control_word_q[15:8] <= wd[15:8];
        end
      end else begin
        if (aw_hs) aw_got_q <= 1'b1;
        if (w_hs)  w_got_q  <= 1'b1;
        if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
      end
    end
  end

  // axi4-lite read path: address latched, table read, then answer
  assign s_axi_arready = ~rd_pend_q & ~s_axi_rvalid;
  wire ar_hs = s_axi_arvalid & s_axi_arready;
  reg  ar_hi_q;

  reg [31:0] rd_mux;
  reg        rd_ok;
  always @* begin
    rd_mux = 32'h0000_0000;
    rd_ok  = ~ar_hi_q & (araddr_q[1:0] == 2'h0);
    if (araddr_q == `CCOMB_OFS_FIXED) begin
      rd_mux = {16'h0000, fixed_control_word_q};
    end else if (araddr_q == `CCOMB_OFS_ASGW) begin
      rd_mux = {16'h0000, assignable_control_word_q};
    end else if (araddr_q == `CCOMB_OFS_STATUS) begin
      rd_mux = {24'h000000, term_op_enable, term_switch_on, term_in};
    end else if (araddr_q == `CCOMB_OFS_FUNC_LO) begin
      rd_mux = func_out[31:0];
    end else if (araddr_q == `CCOMB_OFS_FUNC_HI) begin
      rd_mux = {17'h00000, op_enable, switch_on, func_out[NFN-1:32]};
    end else if (araddr_q[7:5] == 3'h1 && araddr_q[4:2] < 3'h6) begin
      rd_mux = {26'h0000000, term_sel_q[araddr_q[4:2]]};
    end else if (araddr_q[7:6] == 2'h1) begin
      rd_mux = {26'h0000000, atab_rd};
    end else begin
      rd_ok = 1'b0;
    end
    if (!rd_ok) begin
      rd_mux = 32'h0000_0000;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      rd_pend_q    <= 1'b0;
      araddr_q     <= 8'h00;
      ar_hi_q      <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `CCOMB_RESP_OKAY;
    end else begin
      if (ar_hs) begin
        rd_pend_q <= 1'b1;
        araddr_q  <= s_axi_araddr[7:0];
        ar_hi_q   <= |s_axi_araddr[31:8];
      end else if (rd_pend_q) begin
        rd_pend_q    <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= rd_ok ? `CCOMB_RESP_OKAY : `CCOMB_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // ccomb_combiner

// ===== ccomb_checker_asserts.sv
`timescale 1ns/1ps
module ccomb_checker (
  input logic        aclk,
  input logic        aresetn,
  input logic        term_switch_on,
  input logic        term_op_enable,
  input logic        switch_on,
  input logic        op_enable,
  input logic [44:0] func_out,
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic [1:0]  s_axi_bresp,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  no_func_a: assert property (func_out[1:0] == 2'h0)
    else $error("function 0 or 1 raised");
  rst_neutral_a: assert property ($rose(aresetn) |-> ##1 func_out == 45'h18F0_0000_0BC0)
    else $error("functions not neutral after reset");
  sw_and_a: assert property (!term_switch_on |=> !switch_on)
    else $error("switch-on without terminal");
  op_and_a: assert property (!term_op_enable |=> !op_enable)
    else $error("operating enable without terminal");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  wr_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write response late");
  rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_arready ##1 s_axi_rvalid)
    else $error("read response late");
  cover property (switch_on && op_enable);
  cover property (func_out[3] && func_out[4]);
  cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule // ccomb_checker

bind ccomb_combiner ccomb_checker ccomb_checker_inst (.aclk, .aresetn, .term_switch_on,
  .term_op_enable, .switch_on, .op_enable, .func_out, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);

// ===== ccomb_term_model.sv
`timescale 1ns/1ps
// terminal block: levels latched like a sampled input stage
module ccomb_term_model (
  input  logic       aclk,
  input  logic [5:0] lvl,
  input  logic       sw,
  input  logic       op,
  output logic [5:0] term_in,
  output logic       term_switch_on,
  output logic       term_op_enable
);
  always_ff @(posedge aclk) begin
    term_in        <= lvl;
    term_switch_on <= sw;
    term_op_enable <= op;
  end
endmodule // ccomb_term_model

// ===== ccomb_combiner_tb.sv
`timescale 1ns/1ps
module ccomb_combiner_tb;
  logic        aclk, aresetn, sw, op, term_switch_on, term_op_enable, switch_on, op_enable;
  logic [5:0]  lvl, term_in;
  logic [44:0] func_out;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  int          failures, compares, f;
  // AND-combined functions, bit n is function n
  localparam logic [44:0] and_set = 45'h18F0_0000_0BDC;

  ccomb_combiner ccomb_combiner_inst (.aclk, .aresetn, .term_in, .term_switch_on,
    .term_op_enable, .func_out, .switch_on, .op_enable, .s_axi_awaddr, .s_axi_awprot(3'h0),
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  ccomb_term_model ccomb_term_model_inst (.aclk, .lvl, .sw, .op, .term_in, .term_switch_on,
    .term_op_enable);

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task test_done;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task hang;
    failures++;
    $display("BAD %0t no answer", $time);
    test_done();
  endtask

  task chk(input logic [44:0] got, input logic [44:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // 0 arready, 1 rvalid, other bvalid
  function automatic logic pick(input int k);
    case (k)
      0:       pick = s_axi_arready;
      1:       pick = s_axi_rvalid;
      default: pick = s_axi_bvalid;
    endcase
  endfunction

  task automatic wait_hi(input int k);
    int n;
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (pick(k) !== 1'b1 && n < 200);
    if (pick(k) !== 1'b1)
      hang();
    @(posedge aclk);
  endtask

  task wr(input logic [31:0] a, input logic [31:0] d);
    logic pa, pw, ta, tw;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    for (int n = 0; (pa || pw) && n < 200; n++) begin
      @(negedge aclk);
      ta = pa && s_axi_awready;
      tw = pw && s_axi_wready;
      @(posedge aclk);
      if (ta) begin
        pa = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (tw) begin
        pw = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    if (pa || pw)
      hang();
    wait_hi(2);
    s_axi_bready <= 1'b1;
    @(negedge aclk);
    rsp = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
    @(negedge aclk);
  endtask

  task rdr(input logic [31:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    wait_hi(0);
    s_axi_arvalid <= 1'b0;
    wait_hi(1);
    s_axi_rready <= 1'b1;
    @(negedge aclk);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask

  task term(input logic [5:0] v, input logic s, input logic o);
    @(posedge aclk);
    lvl <= v;
    sw <= s;
    op <= o;
    repeat (3) @(posedge aclk);
    @(negedge aclk);
  endtask

  initial begin
    repeat (100000) @(posedge aclk);
    hang();
  end

  initial begin
    {failures, compares} = '0;
    {aresetn, lvl, sw, op, s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rdr(32'h0000_000C);
    chk(rd, 32'h0000_0BC0);
    rdr(32'h0000_0010);
    chk(rd, 32'h0000_18F0);
    $display("test 1 done");
    for (f = 2; f < 45; f++) begin
      wr(32'h0000_0020, 32'(f));
      wr(32'h0000_0024, 32'(f));
      term(6'h01, 1'b0, 1'b0);
      chk(func_out[f], !and_set[f] || f < 5);
      term(6'h03, 1'b0, 1'b0);
      chk(func_out[f], f > 4);
    end
    $display("test 2 done");
    wr(32'h0000_007C, 32'h0000_000C);
    wr(32'h0000_0004, 32'h0000_8000);
    chk(func_out[12], 1'b0);
    wr(32'h0000_0000, 32'h0000_0400);
    chk(func_out[12], 1'b1);
    chk(func_out[4:3], 2'h3);
    wr(32'h0000_0000, 32'h0000_0406);
    chk(func_out[4:3], 2'h0);
    wr(32'h0000_0000, 32'h0000_0402);
    chk(func_out[4:3], 2'h2);
    $display("test 3 done");
    wr(32'h0000_0040, 32'h0000_0006);
    wr(32'h0000_0028, 32'h0000_0006);
    term(6'h04, 1'b0, 1'b0);
    chk(func_out[6], 1'b0);
    wr(32'h0000_0004, 32'h0000_8001);
    chk(func_out[6], 1'b1);
    $display("test 4 done");
    wr(32'h0000_0000, 32'h0000_0409);
    term(6'h00, 1'b1, 1'b1);
    chk({switch_on, op_enable}, 2'h3);
    term(6'h00, 1'b0, 1'b1);
    chk({switch_on, op_enable}, 2'h1);
    rdr(32'h0000_0004);
    chk(rd, 32'h0000_8001);
    rdr(32'h0000_0100);
    chk({rsp, rd}, 34'h2_0000_0000);
    wr(32'h0000_0104, 32'h0000_0001);
    chk(rsp, 2'h2);
    rdr(32'h0000_0004);
    chk(rd, 32'h0000_8001);
    rdr(32'h0000_007C);
    chk(rd, 32'h0000_000C);
    rdr(32'h0000_0028);
    chk(rd, 32'h0000_0006);
    rdr(32'h0000_0008);
    chk(rd, 32'h0000_0080);
    $display("test 5 done");
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rdr(32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk(func_out, 45'h18F0_0000_0BC0);
    $display("test 6 done");
    test_done();
  end
endmodule // ccomb_combiner_tb
